// file: include/lpcr_pkg.sv
// constants and carriers for the l2 prefetch and cache-op register bank
package lpcr_pkg;

  localparam int          AXI_AW        = 12;

  localparam logic [11:0] OFS_SCRATCH_0 = 12'h280;
  localparam logic [11:0] OFS_SCRATCH_1 = 12'h288;
  localparam logic [11:0] OFS_PFT_CTL   = 12'h300;
  localparam logic [11:0] OFS_PFT_CTL_B = 12'h308;
  localparam logic [11:0] OFS_TAG_ADDR  = 12'h600;
  localparam logic [11:0] OFS_TAG_STATE = 12'h608;
  localparam logic [11:0] OFS_DATA      = 12'h610;

  localparam int          PM_LSB        = 12;
  localparam int          PFT_ON_BIT    = 8;
  localparam int          HALT_BIT      = 13;
  localparam int          QUIET_BIT     = 12;
  localparam int          WRI_LSB       = 9;
  localparam int          CODE_BIT      = 8;
  localparam int          TAG_LSB       = 15;
  localparam int          LRU_LSB       = 32;
  localparam int          L2_STATE_BITS = 4;

  localparam logic [19:0] PM_RST        = 20'hF_FFFF;
  localparam logic [15:0] PM_FIXED      = 16'hFFFF;
  localparam logic [31:0] PM_HIGH_ONES  = 32'hFFFF_FFFF;
  localparam logic [1:0]  WRI_RST       = 2'h2;
  localparam logic [1:0]  WRI_RSVD      = 2'h3;
  localparam logic [7:0]  PORT_RST      = 8'hFF;
  localparam logic [63:0] ZERO64        = 64'h0000_0000_0000_0000;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // one tag/data ram entry, used for load capture and store drive
  typedef struct packed {
    logic [32:0] addr;
    logic [11:0] state;
    logic [14:0] lru;
    logic [63:0] data;
  } lpcr_entry_s;

  // settings seen by the l2 prefetcher
  typedef struct packed {
    logic        issue_en;
    logic [51:0] page_mask;
    logic [1:0]  wri_policy;
    logic        code_on;
    logic [7:0]  port_mask;
  } lpcr_pft_s;

endpackage

// file: rtl/lpcr_regs.sv
// axi4-lite register bank for l2 prefetch control and cache-op staging
// Summary of operation
// R1 - two 64-bit scratch words at 0x280/0x288, read/write, reset zero
// R2 - page mask bits 31:12 range 0xFFFFF (4K) down to 0xFFFF0 (64K)
// R3 - mask bits above 31 are treated as ones by the prefetcher
// R4 - prefetching only while enable bit 8 set and unit count nonzero
// R5 - software should set enable only when unit count is above zero
// R6 - unit count bits 7:0 read-only, fixed by build, writes ignored
// R7 - bit 13 of second control reads one while prefetcher paused
// R8 - bit 12 reads one when all trackers aged out and prefetcher idle
// R9 - bits 10:9 select write-invalidate prefetch policy, reset to 2
// R10 - port mask bits 7:0 enable monitoring per port, reset 255
// R11 - load-entry copies tag ram address into tag address bits 47:15
// R12 - store-entry writes tag address register into tag ram address
// R13 - load-entry captures state into 11:0 and lru into 46:32
// R14 - store-entry writes tag state register into tag ram state
// R15 - state field layout depends on l1 sharing and core count
// R16 - load-entry loads data staging register from cacheop_data_stage ram
// R17 - store-entry writes data staging register into cacheop_data_stage ram
// R18 - data staging register is read/write and resets to zero
// R19 - reserved bits read zero and ignore writes
`timescale 1ns/100ps

module lpcr_regs #(
  parameter logic [7:0]  PFT_UNITS   = 8'h04,
  parameter logic [19:0] PM_INIT     = lpcr_pkg::PM_RST,
  parameter logic        PFT_ON_INIT = 1'b0,
  parameter logic        CODE_INIT   = 1'b0,
  parameter bit          SHARED_L1   = 1'b1,
  parameter int          CORES       = 4
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [lpcr_pkg::AXI_AW-1:0]   awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [lpcr_pkg::AXI_AW-1:0]   araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic                          pft_halted,
  input  wire logic                          pft_quiet,
  output lpcr_pkg::lpcr_pft_s                pft_ctrl,
  input  wire logic                          cop_load_req,
  input  wire lpcr_pkg::lpcr_entry_s         cop_load,
  input  wire logic                          cop_store_req,
  output lpcr_pkg::lpcr_entry_s              cop_store,
  output logic                               cop_store_we
);
  import lpcr_pkg::*;

  // presence bits kept above the l2 state: one if shared, else one per core up to eight
  localparam int          PRES       = SHARED_L1 ? 1 : ((CORES > 8) ? 8 : CORES);
  localparam logic [11:0] STATE_KEEP = 12'((1 << (L2_STATE_BITS + PRES)) - 1);

  logic [63:0] scratch_w0;
  logic [63:0] scratch_w1;
  logic [19:0] page_mask;
  logic        prefetch_on;
  logic        halted;
  logic        quiet;
  logic [1:0]  wri_policy;
  logic        code_on;
  logic [7:0]  port_mask;
  logic [32:0] tag_addr;
  logic [11:0] tag_state;
  logic [14:0] lru;
  logic [63:0] data_stage;

  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // reserved positions are constant zero in every view
  wire  [63:0] v_ctl  = {32'h0000_0000, page_mask, 3'h0, prefetch_on, PFT_UNITS};
  wire  [63:0] v_ctlb = {50'h0, halted, quiet, 1'b0, wri_policy, code_on, port_mask};
  wire  [63:0] v_tag  = {16'h0000, tag_addr, 15'h0000};
  wire  [63:0] v_st   = {17'h0000, lru, 20'h0_0000, tag_state};

  // every view is an argument, so a continuous assignment sees each change
  function automatic logic [63:0] view_of(input logic [11:0] a, input logic [63:0] s0, s1, c0, c1, ta, ts, dt);
    logic [11:0] w;
    w = {a[11:3], 3'h0};
    case (w)
      OFS_SCRATCH_0: view_of = s0;
      OFS_SCRATCH_1: view_of = s1;
      OFS_PFT_CTL:   view_of = c0;
      OFS_PFT_CTL_B: view_of = c1;
      OFS_TAG_ADDR:  view_of = ta;
      OFS_TAG_STATE: view_of = ts;
      OFS_DATA:      view_of = dt;
      default:       view_of = ZERO64;
    endcase
  endfunction

  // 32-bit registers own only their low word; the word above is unmapped
  function automatic logic mapped(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:3], 3'h0};
    case (w)
      OFS_SCRATCH_0, OFS_SCRATCH_1, OFS_TAG_ADDR, OFS_TAG_STATE, OFS_DATA:
        mapped = (a[1:0] == 2'h0);
      OFS_PFT_CTL, OFS_PFT_CTL_B:
        mapped = (a[2:0] == 3'h0);
      default:
        mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [63:0] merge(input logic [63:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic hi);
    logic [63:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[(hi ? 32 : 0) + 8*i +: 8] = d[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // only contiguous masks from 4K to 64K pages can be held
  function automatic logic [19:0] legal_pm(input logic [19:0] v);
    logic [3:0] lo;
    lo = v[3] ? (v[2] ? (v[1] ? (v[0] ? 4'hF : 4'hE) : 4'hC) : 4'h8) : 4'h0;
    legal_pm = {PM_FIXED, lo};
  endfunction

  // write channel
  wire         wr_go  = aw_held && w_held && !bvalid;
  wire         wr_ok  = mapped(aw_addr);
  wire  [11:0] wr_w   = {aw_addr[11:3], 3'h0};
  wire  [63:0] wr_cur = view_of(aw_addr, scratch_w0, scratch_w1, v_ctl, v_ctlb, v_tag, v_st, data_stage);
  wire  [63:0] wr_new = merge(wr_cur, w_data, w_strb, aw_addr[2]);
  wire         wr_s0  = wr_go && wr_ok && (wr_w == OFS_SCRATCH_0);
  wire         wr_s1  = wr_go && wr_ok && (wr_w == OFS_SCRATCH_1);
  wire         wr_ctl = wr_go && wr_ok && (wr_w == OFS_PFT_CTL);
  wire         wr_cb  = wr_go && wr_ok && (wr_w == OFS_PFT_CTL_B);
  wire         wr_tag = wr_go && wr_ok && (wr_w == OFS_TAG_ADDR);
  wire         wr_st  = wr_go && wr_ok && (wr_w == OFS_TAG_STATE);
  wire         wr_dat = wr_go && wr_ok && (wr_w == OFS_DATA);

  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel: one-cycle answer from the current view
  wire  [63:0] rd_view = view_of(araddr, scratch_w0, scratch_w1, v_ctl, v_ctlb, v_tag, v_st, data_stage);
  wire         rd_ok   = mapped(araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_ok ? (araddr[2] ? rd_view[63:32] : rd_view[31:0]) : 32'h0000_0000;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // scratch words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scratch_w0 <= ZERO64;
      scratch_w1 <= ZERO64;
    end else begin
      if (wr_s0) scratch_w0 <= wr_new;  // see R1
      if (wr_s1) scratch_w1 <= wr_new;  // see R1
    end
  end

  // prefetch control; unit count is never stored, so writes to it vanish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_mask   <= legal_pm(PM_INIT);
      prefetch_on <= PFT_ON_INIT;
    end else if (wr_ctl) begin
      page_mask   <= legal_pm(wr_new[PM_LSB +: 20]);  // see R2
      prefetch_on <= wr_new[PFT_ON_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wri_policy <= WRI_RST;   // see R9
      code_on    <= CODE_INIT;
      port_mask  <= PORT_RST;  // see R10
    end else if (wr_cb) begin
      // the reserved policy code is refused, the old one stays
      if (wr_new[WRI_LSB +: 2] != WRI_RSVD) wri_policy <= wr_new[WRI_LSB +: 2];  // see R9
      code_on    <= wr_new[CODE_BIT];
      port_mask  <= wr_new[7:0];  // see R10
    end
  end

  // status from the prefetcher, same clock, one flop for a clean read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted <= 1'b0;
      quiet  <= 1'b0;
    end else begin
      halted <= pft_halted;  // see R7
      quiet  <= pft_quiet;   // see R8
    end
  end

  // staging registers: a load-entry beats a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_addr <= 33'h0_0000_0000;
    end else if (cop_load_req) begin
      tag_addr <= cop_load.addr;  // see R11
    end else if (wr_tag) begin
      tag_addr <= wr_new[TAG_LSB +: 33];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_state <= 12'h000;
      lru       <= 15'h0000;
    end else if (cop_load_req) begin
      tag_state <= cop_load.state & STATE_KEEP;  // see R13, R15
      lru       <= cop_load.lru;                 // see R13
    end else if (wr_st) begin
      tag_state <= wr_new[11:0] & STATE_KEEP;    // see R15
      lru       <= wr_new[LRU_LSB +: 15];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_stage <= ZERO64;  // see R18
    end else if (cop_load_req) begin
      data_stage <= cop_load.data;  // see R16
    end else if (wr_dat) begin
      data_stage <= wr_new;  // see R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cop_store_we <= 1'b0;
    end else begin
      cop_store_we <= cop_store_req;  // see R12, R14, R17
    end
  end

  // the ram takes the staged entry while cop_store_we is high
  assign cop_store.addr  = tag_addr;    // see R12
  assign cop_store.state = tag_state;   // see R14
  assign cop_store.lru   = lru;         // see R14
  assign cop_store.data  = data_stage;  // see R17

  assign pft_ctrl.issue_en   = prefetch_on && (PFT_UNITS != 8'h00);  // see R4, R5
  assign pft_ctrl.page_mask  = {PM_HIGH_ONES, page_mask};            // see R3
  assign pft_ctrl.wri_policy = wri_policy;
  assign pft_ctrl.code_on    = code_on;
  assign pft_ctrl.port_mask  = port_mask;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_scratch_write;
    wr_s0 && !aw_addr[2] && (w_strb == 4'hF) |=> scratch_w0[31:0] == $past(w_data);
  endproperty
  a_scratch_write: assert property (p_scratch_write)  // see R1
    else $error("scratch word did not take write");

  property p_mask_range;
    pft_ctrl.page_mask[51:4] == {PM_HIGH_ONES, PM_FIXED};
  endproperty
  a_mask_range: assert property (p_mask_range)  // see R2, R3
    else $error("page mask outside supported range");

  property p_issue_gate;
    pft_ctrl.issue_en |-> v_ctl[PFT_ON_BIT] && (v_ctl[7:0] != 8'h00);
  endproperty
  a_issue_gate: assert property (p_issue_gate)  // see R4
    else $error("prefetch issued without enable or units");

  property p_units_fixed;
    wr_ctl |=> v_ctl[7:0] == PFT_UNITS;
  endproperty
  a_units_fixed: assert property (p_units_fixed)  // see R6
    else $error("unit count changed by write");

  property p_halt_seen;
    pft_halted ##1 (arvalid && arready && (araddr == OFS_PFT_CTL_B)) |=> rdata[HALT_BIT];
  endproperty
  a_halt_seen: assert property (p_halt_seen)  // see R7
    else $error("paused status not read back");

  property p_quiet_seen;
    pft_quiet |=> v_ctlb[QUIET_BIT];
  endproperty
  a_quiet_seen: assert property (p_quiet_seen)  // see R8
    else $error("idle status not reflected");

  property p_reset_ctl;
    $past(!aresetn) |-> wri_policy == WRI_RST && port_mask == PORT_RST && data_stage == ZERO64;
  endproperty
  a_reset_ctl: assert property (p_reset_ctl)  // see R9, R10, R18
    else $error("control reset values wrong");

  property p_wri_legal;
    wri_policy != WRI_RSVD;
  endproperty
  a_wri_legal: assert property (p_wri_legal)  // see R9
    else $error("reserved policy code held");

  property p_load_capture;
    cop_load_req |=> tag_addr == $past(cop_load.addr) && lru == $past(cop_load.lru)
                     && data_stage == $past(cop_load.data);
  endproperty
  a_load_capture: assert property (p_load_capture)  // see R11, R13, R16
    else $error("load-entry not captured");

  property p_store_drive;
    cop_store_req && !cop_load_req && !wr_go |=> cop_store_we
      && cop_store.addr == $past(tag_addr) && cop_store.data == $past(data_stage);
  endproperty
  a_store_drive: assert property (p_store_drive)  // see R12, R14, R17
    else $error("store-entry did not drive staged entry");

  property p_reserved_zero;
    v_tag[63:48] == 16'h0000 && v_tag[14:0] == 15'h0000 && (tag_state & ~STATE_KEEP) == 12'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)  // see R15, R19
    else $error("reserved bits not zero");

  property p_write_answer;
    wr_go |=> bvalid && (bresp == ($past(wr_ok) ? RESP_OKAY : RESP_SLVERR));
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing or wrong");

endmodule

// file: testbench/lpcr_regs_tb_top.sv
// self-checking bench for the l2 prefetch and cache-op register bank
`timescale 1ns/100ps

module lpcr_regs_tb_top;
  import lpcr_pkg::*;

  logic               aclk;
  logic               aresetn;
  logic [AXI_AW-1:0]  awaddr;
  logic               awvalid;
  logic [31:0]        wdata;
  logic               wvalid;
  logic               bready;
  logic [AXI_AW-1:0]  araddr;
  logic               arvalid;
  logic               rready;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic               pft_halted, pft_quiet, cop_load_req, cop_store_req, cop_store_we;
  lpcr_pft_s          pft_ctrl;
  lpcr_entry_s        cop_load;
  lpcr_entry_s        cop_store;
  int                 fails;
  int                 tests_run;
  logic [63:0]        e;

  lpcr_regs u_dut (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .awaddr        (awaddr),
    .awprot        (3'h0),
    .awvalid       (awvalid),
    .awready       (awready),
    .wdata         (wdata),
    .wstrb         (4'hF),
    .wvalid        (wvalid),
    .wready        (wready),
    .bresp         (bresp),
    .bvalid        (bvalid),
    .bready        (bready),
    .araddr        (araddr),
    .arprot        (3'h0),
    .arvalid       (arvalid),
    .arready       (arready),
    .rdata         (rdata),
    .rresp         (rresp),
    .rvalid        (rvalid),
    .rready        (rready),
    .pft_halted    (pft_halted),
    .pft_quiet     (pft_quiet),
    .pft_ctrl      (pft_ctrl),
    .cop_load_req  (cop_load_req),
    .cop_load      (cop_load),
    .cop_store_req (cop_store_req),
    .cop_store     (cop_store),
    .cop_store_we  (cop_store_we)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // both channels offered together, each released as soon as it is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    chk({62'h0, bresp}, {62'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    chk({30'h0, rresp, rdata}, {30'h0, er, ed});
  endtask

  // halves are independent, so a 64-bit value is two word reads
  task automatic rd64(input logic [11:0] a, input logic [63:0] ed);
    rd(a, ed[31:0], RESP_OKAY);
    rd(a + 12'h004, ed[63:32], RESP_OKAY);
  endtask

  task automatic wr64(input logic [11:0] a, input logic [63:0] d);
    wr(a, d[31:0], RESP_OKAY);
    wr(a + 12'h004, d[63:32], RESP_OKAY);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_sim();
  end

  initial begin
    fails = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {pft_halted, pft_quiet, cop_load_req, cop_store_req} = '0;
    cop_load = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;

    rd64(OFS_SCRATCH_0, ZERO64);
    rd64(OFS_SCRATCH_1, ZERO64);
    rd(OFS_PFT_CTL, 32'hFFFF_F004, RESP_OKAY);
    rd(OFS_PFT_CTL_B, 32'h0000_04FF, RESP_OKAY);
    rd64(OFS_TAG_ADDR, ZERO64);
    rd64(OFS_TAG_STATE, ZERO64);
    rd64(OFS_DATA, ZERO64);
    $display("reset values done");

    wr64(OFS_SCRATCH_0, 64'hFFFF_FFFF_FFFF_FFFF);
    wr64(OFS_SCRATCH_1, 64'hA5A5_0F0F_1234_5678);
    rd64(OFS_SCRATCH_0, 64'hFFFF_FFFF_FFFF_FFFF);
    rd64(OFS_SCRATCH_1, 64'hA5A5_0F0F_1234_5678);
    $display("scratch done");

    // count and reserved bits must survive an all-ones write
    wr(OFS_PFT_CTL, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_PFT_CTL, 32'hFFFF_F104, RESP_OKAY);
    chk({63'h0, pft_ctrl.issue_en}, 64'h1);
    wr(OFS_PFT_CTL, 32'hFFFF_0100, RESP_OKAY);
    rd(OFS_PFT_CTL, 32'hFFFF_0104, RESP_OKAY);
    chk({12'h0, pft_ctrl.page_mask}, {12'h0, 32'hFFFF_FFFF, 20'hF_FFF0});
    wr(OFS_PFT_CTL, 32'hFFFF_F000, RESP_OKAY);
    chk({63'h0, pft_ctrl.issue_en}, 64'h0);
    $display("prefetch control done");

    wr(OFS_PFT_CTL_B, 32'h0000_3FFF, RESP_OKAY);
    rd(OFS_PFT_CTL_B, 32'h0000_05FF, RESP_OKAY);
    chk({63'h0, pft_ctrl.code_on}, 64'h1);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_PFT_CTL_B, {21'h0, i[1:0], 9'h05A}, RESP_OKAY);
      rd(OFS_PFT_CTL_B, {21'h0, i[1:0], 9'h05A}, RESP_OKAY);
      chk({62'h0, pft_ctrl.wri_policy}, {62'h0, i[1:0]});
    end
    chk({56'h0, pft_ctrl.port_mask}, 64'h5A);
    // reserved policy code leaves the last legal one in place
    wr(OFS_PFT_CTL_B, {21'h0, WRI_RSVD, 9'h05A}, RESP_OKAY);
    rd(OFS_PFT_CTL_B, 32'h0000_045A, RESP_OKAY);
    @(posedge aclk);
    pft_halted <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_PFT_CTL_B, 32'h0000_245A, RESP_OKAY);
    pft_halted <= 1'b0;
    pft_quiet  <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_PFT_CTL_B, 32'h0000_145A, RESP_OKAY);
    pft_quiet <= 1'b0;
    $display("prefetch second control done");

    @(posedge aclk);
    cop_load_req <= 1'b1;
    cop_load     <= '{addr: 33'h1_2345_6789, state: 12'hFFF, lru: 15'h7ABC, data: 64'hDEAD_BEEF_0BAD_F00D};
    @(posedge aclk);
    cop_load_req <= 1'b0;
    e = {16'h0, 33'h1_2345_6789, 15'h0};
    rd64(OFS_TAG_ADDR, e);
    // one shared first level cache keeps four plus one state bits
    rd64(OFS_TAG_STATE, {17'h0, 15'h7ABC, 20'h0, 12'h01F});
    rd64(OFS_DATA, 64'hDEAD_BEEF_0BAD_F00D);
    $display("load entry done");

    wr64(OFS_TAG_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
    rd64(OFS_TAG_ADDR, 64'h0000_FFFF_FFFF_8000);
    wr64(OFS_TAG_STATE, 64'hFFFF_FFFF_FFFF_FFFF);
    wr64(OFS_DATA, 64'h0123_4567_89AB_CDEF);
    @(posedge aclk);
    cop_store_req <= 1'b1;
    @(posedge aclk);
    cop_store_req <= 1'b0;
    #1;
    chk({63'h0, cop_store_we}, 64'h1);
    chk({31'h0, cop_store.addr}, {31'h0, 33'h1_FFFF_FFFF});
    chk({37'h0, cop_store.lru, cop_store.state}, {37'h0, 15'h7FFF, 12'h01F});
    chk(cop_store.data, 64'h0123_4567_89AB_CDEF);
    @(posedge aclk);
    #1;
    chk({63'h0, cop_store_we}, 64'h0);
    $display("store entry done");

    wr(12'h400, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(12'h400, 32'h0, RESP_SLVERR);
    rd(12'h304, 32'h0, RESP_SLVERR);
    wr(12'h282, 32'h1234_5678, RESP_SLVERR);
    rd64(OFS_SCRATCH_0, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("unmapped access done");

    // a second reset must bring back values that the tests changed
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd64(OFS_SCRATCH_0, ZERO64);
    rd(OFS_PFT_CTL, 32'hFFFF_F004, RESP_OKAY);
    rd(OFS_PFT_CTL_B, 32'h0000_04FF, RESP_OKAY);
    rd64(OFS_DATA, ZERO64);
    $display("second reset done");
    end_sim();
  end

endmodule
